// ==== design/sph_pkg.sv ====
// Overview of operation
// - Select, write strobe low: latch command byte
// - Select, read strobe low: port drives status
// - Idle or both strobes low: no transfer
// - Acknowledge, read strobe low: latch byte out
// - Acknowledge, write strobe low: byte into latch
// - Host never selects and acknowledges together
// - Command write latches and interrupts microcontroller
// - Request raised only for parametric commands
// - After parameters, update status, raise interrupt
// - Microcontroller latch read requests next byte
// - Latch captures on write strobe rising edge
// - Microcontroller latch write sets the request
// - Completed byte transfer clears the request
// - Interrupt raised only while line is low
// - Command top bit set clears host interrupt
// - Host acknowledges every interrupt to avoid deadlock
// - Host sets pointer and count before command
// - Host starts commands; data follows requests
// - Host may serve request by programmed transfers
// - Command: acknowledge bit seven, opcode bits 0-3
// - Status bit zero mirrors host interrupt
// - Status bit one: DMA busy, gates request
package sph_pkg;
	// ***********************************
	// Link layout
	// ***********************************
	localparam int unsigned CMD_ACK_BIT  = 7;
	localparam int unsigned ST_INT_BIT   = 0;
	localparam int unsigned ST_DMA_BIT   = 1;
	localparam logic [7:0]  BUS_IDLE     = 8'hff;
	localparam logic [7:0]  STATUS_RST   = 8'h00;
	// Strobe width, long enough for two-stage sync plus drive
	localparam int unsigned STROBE_CYC   = 8;
	localparam int unsigned MEM_WORDS    = 16;
	// ***********************************
	// Microcontroller register map
	// ***********************************
	localparam logic [7:0]  MC_LATCH     = 8'h00;
	localparam logic [7:0]  MC_STATUS    = 8'h04;
	localparam logic [7:0]  MC_CTRL      = 8'h08;
	localparam int unsigned CTRL_RAISE   = 0;
	localparam int unsigned CTRL_DIR_IN  = 1;
	// ***********************************
	// Host register map
	// ***********************************
	localparam logic [7:0]  H_CMD        = 8'h00;
	localparam logic [7:0]  H_STATUS     = 8'h04;
	localparam logic [7:0]  H_DMA_CTRL   = 8'h08;
	localparam logic [7:0]  H_DMA_CNT    = 8'h0c;
	localparam logic [7:0]  H_MEM_PTR    = 8'h10;
	localparam logic [7:0]  H_MEM_DATA   = 8'h14;
	localparam int unsigned DMA_EN_BIT   = 0;
	localparam int unsigned DMA_TOMEM    = 1;
	typedef enum logic [2:0] {
		HS_IDLE, HS_STROBE, HS_RELEASE, HS_DRAIN
	} sph_hstate_t;
endpackage

// ==== design/sph_link_if.sv ====
`timescale 1ns/1ns
interface sph_link_if;
	logic       host_port_select_n;
	logic       transfer_acknowledge_n;
	logic       rd_n;
	logic       wr_n;
	logic       transfer_request;
	logic       host_irq;
	logic [7:0] host_dat;
	logic       host_oe;
	logic [7:0] dev_dat;
	logic       dev_oe;
	// Resolved data bus, pulled high when nobody drives
	wire  [7:0] bus = host_oe ? host_dat : (dev_oe ? dev_dat : sph_pkg::BUS_IDLE);
	modport host (
		output host_port_select_n, transfer_acknowledge_n, rd_n, wr_n,
		output host_dat, host_oe,
		input  transfer_request, host_irq, bus
	);
	modport dev (
		input  host_port_select_n, transfer_acknowledge_n, rd_n, wr_n, bus,
		output transfer_request, host_irq, dev_dat, dev_oe
	);
endinterface // sph_link_if

// ==== design/sph_dev_end.sv ====
`timescale 1ns/1ns
module sph_dev_end (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Link to host
	sph_link_if.dev          link,
	// Microcontroller Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Command interrupt to microcontroller
	output logic             mc_irq_o
);
	// ***********************************
	// Link input synchronisers
	// ***********************************
	// Order: sel_n, ack_n, rd_n, wr_n, data[7:0]
	logic [11:0] s1_q;
	logic [11:0] s2_q;
	logic [11:0] prev_q;
	// Two stages before any logic looks at the pins
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s1_q   <= 12'hfff;
			s2_q   <= 12'hfff;
			prev_q <= 12'hfff;
		end
		else
		begin
			s1_q   <= {link.host_port_select_n, link.transfer_acknowledge_n,
				link.rd_n, link.wr_n, link.bus};
			s2_q   <= s1_q;
			prev_q <= s2_q;
		end
	end

	logic       sel;
	logic       transfer_acknowledge;
	logic       rd_low;
	logic       wr_low;
	logic       wr_rise;
	logic       rd_rise;
	logic [7:0] bus_s;
	assign sel     = ~s2_q[11];
	assign transfer_acknowledge    = ~s2_q[10];
	assign rd_low  = ~s2_q[9];
	assign wr_low  = ~s2_q[8];
	assign bus_s   = s2_q[7:0];
	// Strobe end while still selected; counts only if the other strobe is high by then
	assign wr_rise = ~prev_q[8] & s2_q[8] & s2_q[9];
	assign rd_rise = ~prev_q[9] & s2_q[9] & s2_q[8];

	logic host_cmd_wr;
	logic dma_wr;
	logic dma_rd_done;
	assign host_cmd_wr = wr_rise & sel & ~transfer_acknowledge;
	assign dma_wr      = wr_rise & transfer_acknowledge & ~sel;
	assign dma_rd_done = rd_rise & transfer_acknowledge & ~sel;

	// ***********************************
	// Microcontroller bus decode
	// ***********************************
	logic wb_go;
	logic lat_rd;
	logic lat_wr;
	logic st_wr;
	logic ctl_wr;
	assign wb_go  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign lat_rd = wb_go & ~wb_we_i & (wb_adr_i == sph_pkg::MC_LATCH);
	assign lat_wr = wb_go & wb_we_i & wb_sel_i[0] & (wb_adr_i == sph_pkg::MC_LATCH);
	assign st_wr  = wb_go & wb_we_i & wb_sel_i[0] & (wb_adr_i == sph_pkg::MC_STATUS);
	assign ctl_wr = wb_go & wb_we_i & wb_sel_i[0] & (wb_adr_i == sph_pkg::MC_CTRL);

	logic [7:0] latch_q;
	logic [7:0] status_q;
	logic       dma_q;
	logic       dir_in_q;
	logic       irq_q;
	logic       drq_q;
	logic       cmd_pend_q;
	logic       raise;
	assign raise = ctl_wr & wb_dat_i[sph_pkg::CTRL_RAISE] & ~irq_q;

	// ***********************************
	// Command/data latch
	// ***********************************
	// Host side wins a same-cycle collision with firmware
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			latch_q <= 8'h00;
		else if (host_cmd_wr | dma_wr)
			latch_q <= bus_s;
		else if (lat_wr)
			latch_q <= wb_dat_i[7:0];
	end

	// Pending command flag; new command beats a firmware read
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			cmd_pend_q <= 1'b0;
		else if (host_cmd_wr)
			cmd_pend_q <= 1'b1;
		else if (lat_rd)
			cmd_pend_q <= 1'b0;
	end

	// ***********************************
	// Status and control
	// ***********************************
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			status_q <= sph_pkg::STATUS_RST;
			dma_q    <= 1'b0;
			dir_in_q <= 1'b0;
		end
		else
		begin
			if (st_wr)
			begin
				status_q <= wb_dat_i[7:0];
				dma_q    <= wb_dat_i[sph_pkg::ST_DMA_BIT];
			end
			if (ctl_wr)
				dir_in_q <= wb_dat_i[sph_pkg::CTRL_DIR_IN];
		end
	end

	// Host interrupt: firmware raise beats an acknowledging command
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_q <= 1'b0;
		else if (raise)
			irq_q <= 1'b1;
		else if (host_cmd_wr & bus_s[sph_pkg::CMD_ACK_BIT])
			irq_q <= 1'b0;
	end

	// Transfer request; set wins over the acknowledge that clears it
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			drq_q <= 1'b0;
		else if (!dma_q)
			drq_q <= 1'b0;
		else if (lat_wr | (lat_rd & dir_in_q))
			drq_q <= 1'b1;
		else if (dma_wr | dma_rd_done)
			drq_q <= 1'b0;
	end

	// ***********************************
	// Link outputs
	// ***********************************
	logic [7:0] dat_q;
	logic       oe_q;
	// Drive only for a clean single read strobe
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			dat_q <= 8'h00;
			oe_q  <= 1'b0;
		end
		else
		begin
			oe_q  <= (sel ^ transfer_acknowledge) & rd_low & ~wr_low;
			dat_q <= transfer_acknowledge ? latch_q
				: {status_q[7:2], dma_q, irq_q};
		end
	end
	assign link.dev_dat          = dat_q;
	assign link.dev_oe           = oe_q;
	assign link.transfer_request = drq_q;
	assign link.host_irq         = irq_q;
	assign mc_irq_o              = cmd_pend_q;

	// ***********************************
	// Wishbone answer
	// ***********************************
	// One wait state; unmapped reads return zero
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end
		else
		begin
			wb_ack_o <= wb_go;
			unique case (wb_adr_i)
				sph_pkg::MC_LATCH:  wb_dat_o <= {24'h0, latch_q};
				sph_pkg::MC_STATUS: wb_dat_o <= {24'h0, status_q[7:2], dma_q, irq_q};
				sph_pkg::MC_CTRL:   wb_dat_o <= {28'h0, cmd_pend_q, drq_q, dir_in_q, irq_q};
				default:            wb_dat_o <= 32'h0;
			endcase
		end
	end
endmodule // sph_dev_end

// ==== design/sph_host_end.sv ====
// Our own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ns
module sph_host_end (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Link to device
	sph_link_if.host         link,
	// Host software Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o
);
	// ***********************************
	// Input synchronisers
	// ***********************************
	logic [9:0] s1_q;
	logic [9:0] s2_q;
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s1_q <= 10'h0ff;
			s2_q <= 10'h0ff;
		end
		else
		begin
			s1_q <= {link.transfer_request, link.host_irq, link.bus};
			s2_q <= s1_q;
		end
	end

	// ***********************************
	// Registers and memory
	// ***********************************
	logic wb_go;
	logic we;
	assign wb_go = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign we    = wb_go & wb_we_i & wb_sel_i[0];

	sph_pkg::sph_hstate_t st_q;
	logic [7:0] mem_q [sph_pkg::MEM_WORDS];
	logic [3:0] ptr_q;
	logic [7:0] cnt_q;
	logic [1:0] dctl_q;
	logic [7:0] stat_q;
	logic [7:0] out_q;
	logic       is_dma_q;
	logic       is_rd_q;
	logic [3:0] tm_q;
	logic       cmd_go;
	logic       st_go;
	logic       dma_go;
	logic       dma_done;
	assign cmd_go   = (st_q == sph_pkg::HS_IDLE) & we & (wb_adr_i == sph_pkg::H_CMD);
	assign st_go    = (st_q == sph_pkg::HS_IDLE) & we & (wb_adr_i == sph_pkg::H_STATUS);
	// Commands outrank data; request is served only when programmed
	assign dma_go   = (st_q == sph_pkg::HS_IDLE) & ~cmd_go & ~st_go & s2_q[9]
		& dctl_q[sph_pkg::DMA_EN_BIT] & (cnt_q != 8'h00);
	assign dma_done = (st_q == sph_pkg::HS_RELEASE) & is_dma_q;

	// Pointer, count, control and memory window
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ptr_q  <= 4'h0;
			cnt_q  <= 8'h00;
			dctl_q <= 2'h0;
		end
		else if (dma_done)
		begin
			ptr_q <= ptr_q + 4'h1;
			cnt_q <= cnt_q - 8'h01;
		end
		else if (we)
		begin
			unique case (wb_adr_i)
				sph_pkg::H_DMA_CTRL: dctl_q <= wb_dat_i[1:0];
				sph_pkg::H_DMA_CNT:  cnt_q  <= wb_dat_i[7:0];
				sph_pkg::H_MEM_PTR:  ptr_q  <= wb_dat_i[3:0];
				default:             ;
			endcase
		end
	end

	// Memory written by software or by a device-to-memory cycle
	always_ff @(posedge clk_i)
	begin
		if (dma_done & is_rd_q)
			mem_q[ptr_q] <= s2_q[7:0];
		else if (we & (wb_adr_i == sph_pkg::H_MEM_DATA))
			mem_q[ptr_q] <= wb_dat_i[7:0];
	end

	// ***********************************
	// Link sequencer
	// ***********************************
	// Select and acknowledge are never low together
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st_q     <= sph_pkg::HS_IDLE;
			tm_q     <= 4'h0;
			is_dma_q <= 1'b0;
			is_rd_q  <= 1'b0;
			out_q    <= 8'h00;
			stat_q   <= 8'h00;
		end
		else
		begin
			unique case (st_q)
				sph_pkg::HS_IDLE:
				begin
					tm_q <= 4'(sph_pkg::STROBE_CYC - 1);
					if (cmd_go | st_go | dma_go)
						st_q <= sph_pkg::HS_STROBE;
					is_dma_q <= dma_go;
					is_rd_q  <= st_go | (dma_go & dctl_q[sph_pkg::DMA_TOMEM]);
					out_q    <= cmd_go ? wb_dat_i[7:0] : mem_q[ptr_q];
				end
				sph_pkg::HS_STROBE:
				begin
					tm_q <= tm_q - 4'h1;
					if (tm_q == 4'h0)
					begin
						st_q <= sph_pkg::HS_RELEASE;
						if (is_rd_q & ~is_dma_q)
							stat_q <= s2_q[7:0];
					end
				end
				sph_pkg::HS_RELEASE:
					st_q <= is_dma_q ? sph_pkg::HS_DRAIN : sph_pkg::HS_IDLE;
				sph_pkg::HS_DRAIN:
					// Wait for the request to fall before the next byte
					if (!s2_q[9])
						st_q <= sph_pkg::HS_IDLE;
				default:
					st_q <= sph_pkg::HS_IDLE;
			endcase
		end
	end

	// Pins from flops: strobe low in STROBE, select held through RELEASE
	logic sel_n_q;
	logic ack_n_q;
	logic rd_n_q;
	logic wr_n_q;
	logic oe_q;
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sel_n_q <= 1'b1;
			ack_n_q <= 1'b1;
			rd_n_q  <= 1'b1;
			wr_n_q  <= 1'b1;
			oe_q    <= 1'b0;
		end
		else
		begin
			sel_n_q <= ~((cmd_go | st_go) | ((st_q == sph_pkg::HS_STROBE) & ~is_dma_q));
			ack_n_q <= ~(dma_go | ((st_q == sph_pkg::HS_STROBE) & is_dma_q));
			rd_n_q  <= ~((st_go | (dma_go & dctl_q[sph_pkg::DMA_TOMEM]))
				| ((st_q == sph_pkg::HS_STROBE) & is_rd_q & (tm_q != 4'h0)));
			wr_n_q  <= ~((cmd_go | (dma_go & ~dctl_q[sph_pkg::DMA_TOMEM]))
				| ((st_q == sph_pkg::HS_STROBE) & ~is_rd_q & (tm_q != 4'h0)));
			oe_q    <= (cmd_go | (dma_go & ~dctl_q[sph_pkg::DMA_TOMEM]))
				| ((st_q == sph_pkg::HS_STROBE) & ~is_rd_q);
		end
	end
	assign link.host_port_select_n     = sel_n_q;
	assign link.transfer_acknowledge_n = ack_n_q;
	assign link.rd_n                   = rd_n_q;
	assign link.wr_n                   = wr_n_q;
	assign link.host_dat               = out_q;
	assign link.host_oe                = oe_q;

	// ***********************************
	// Wishbone answer
	// ***********************************
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end
		else
		begin
			wb_ack_o <= wb_go;
			unique case (wb_adr_i)
				sph_pkg::H_STATUS:   wb_dat_o <= {21'h0, st_q != sph_pkg::HS_IDLE,
					s2_q[9], s2_q[8], stat_q};
				sph_pkg::H_DMA_CTRL: wb_dat_o <= {30'h0, dctl_q};
				sph_pkg::H_DMA_CNT:  wb_dat_o <= {24'h0, cnt_q};
				sph_pkg::H_MEM_PTR:  wb_dat_o <= {28'h0, ptr_q};
				sph_pkg::H_MEM_DATA: wb_dat_o <= {24'h0, mem_q[ptr_q]};
				default:             wb_dat_o <= 32'h0;
			endcase
		end
	end
endmodule // sph_host_end

// ==== test/sph_link_checker.sv ====
`timescale 1ns/1ns
// ****************************
// Link protocol checker
// ****************************
module sph_link_checker (
	// Clock and reset
	input wire logic       clk_i,
	input wire logic       rst_i,
	// Host driven pins
	input wire logic       host_port_select_n,
	input wire logic       transfer_acknowledge_n,
	input wire logic       rd_n,
	input wire logic       wr_n,
	input wire logic [7:0] host_dat,
	input wire logic       host_oe,
	// Device driven pins
	input wire logic       transfer_request,
	input wire logic       host_irq,
	input wire logic       dev_oe
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// Strobes only ever qualified by exactly one of select or acknowledge
	sel_ack_excl_a: assert property (
		!(!host_port_select_n && !transfer_acknowledge_n))
		else $error("select and acknowledge low together");
	strobe_excl_a: assert property (
		!(!rd_n && !wr_n))
		else $error("both strobes low");
	strobe_frame_a: assert property (
		(!rd_n || !wr_n) |-> (host_port_select_n != transfer_acknowledge_n))
		else $error("strobe without one qualifier");
	// Fixed widths keep the far side's two-flop sampling safe
	strobe_width_a: assert property (
		$fell(rd_n) |-> !rd_n [*8] ##1 rd_n)
		else $error("read strobe width wrong");
	select_width_a: assert property (
		$fell(host_port_select_n) |-> !host_port_select_n [*8] ##1 !host_port_select_n
			##1 host_port_select_n)
		else $error("select width wrong");
	// Written byte must not move while the strobe is low
	data_hold_a: assert property (
		(!wr_n && $past(!wr_n)) |-> ($stable(host_dat) && host_oe))
		else $error("write data not held");
	dev_answer_a: assert property (
		$fell(rd_n) |-> ##[1:6] dev_oe)
		else $error("device did not drive on read");
	irq_clear_a: assert property (
		($rose(wr_n) && !host_port_select_n && host_dat[7]) |-> ##[1:8] !host_irq)
		else $error("acknowledge command kept interrupt");
	req_clear_a: assert property (
		(($rose(wr_n) || $rose(rd_n)) && !transfer_acknowledge_n)
			|-> ##[1:8] !transfer_request)
		else $error("request not cleared after transfer");
	dma_cause_a: assert property (
		$fell(transfer_acknowledge_n) |-> transfer_request)
		else $error("acknowledge without request");
endmodule // sph_link_checker

// ==== test/slave_port_host_interface_tb.sv ====
`timescale 1ns/1ns
// ****************************
// Two-end bench
// ****************************
module slave_port_host_interface_tb;
	// Index 0 is the host bus, index 1 the microcontroller bus
	logic        clk_i     = 1'b0;
	logic        rst_i     = 1'b1;
	logic        b_cyc [2] = '{2{1'b0}};
	logic        b_we [2]  = '{2{1'b0}};
	logic [7:0]  b_adr [2] = '{2{8'h00}};
	logic [31:0] b_wd [2]  = '{2{32'h0}};
	logic [31:0] b_rd [2];
	logic        b_ack [2];
	logic        mc_irq;
	int          n_errors  = 0;
	int          cmp_count = 0;

	// Clock
	always #2 clk_i = ~clk_i;

	// Both ends face each other
	sph_link_if link();
	sph_host_end sph_host_end_inst (.clk_i(clk_i), .rst_i(rst_i), .link(link),
		.wb_cyc_i(b_cyc[0]), .wb_stb_i(b_cyc[0]), .wb_we_i(b_we[0]), .wb_adr_i(b_adr[0]),
		.wb_sel_i(4'h1), .wb_dat_i(b_wd[0]), .wb_dat_o(b_rd[0]), .wb_ack_o(b_ack[0]));
	sph_dev_end sph_dev_end_inst (.clk_i(clk_i), .rst_i(rst_i), .link(link),
		.wb_cyc_i(b_cyc[1]), .wb_stb_i(b_cyc[1]), .wb_we_i(b_we[1]), .wb_adr_i(b_adr[1]),
		.wb_sel_i(4'h1), .wb_dat_i(b_wd[1]), .wb_dat_o(b_rd[1]), .wb_ack_o(b_ack[1]),
		.mc_irq_o(mc_irq));
	sph_link_checker sph_link_checker_inst (.clk_i(clk_i), .rst_i(rst_i),
		.host_port_select_n(link.host_port_select_n),
		.transfer_acknowledge_n(link.transfer_acknowledge_n),
		.rd_n(link.rd_n), .wr_n(link.wr_n), .host_dat(link.host_dat), .host_oe(link.host_oe),
		.transfer_request(link.transfer_request), .host_irq(link.host_irq),
		.dev_oe(link.dev_oe));

	// ****************************
	// Access tasks
	// ****************************
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One classic cycle; request held until ack is sampled high
	task automatic bus(input bit dv, input bit w, input logic [7:0] a, input logic [7:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		b_cyc[dv] <= 1'b1;
		b_we[dv]  <= w;
		b_adr[dv] <= a;
		b_wd[dv]  <= {24'h000000, d};
		do
			@(posedge clk_i);
		while (b_ack[dv] !== 1'b1 && ++n < 100);
		// A slave that never answers ends the run as a failure
		if (b_ack[dv] !== 1'b1)
		begin
			n_errors++;
			test_done;
		end
		q = b_rd[dv];
		b_cyc[dv] <= 1'b0;
	endtask

	task automatic wr(input bit dv, input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(dv, 1'b1, a, d, q);
	endtask

	task automatic rdc(input bit dv, input logic [7:0] a, input logic [31:0] e, input string nm);
		logic [31:0] q;
		bus(dv, 1'b0, a, 8'h00, q);
		chk(nm, e, q);
	endtask

	// Bounded wait on a register field, no fixed cycle assumption
	task automatic poll(input bit dv, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e, input string nm);
		logic [31:0] q;
		int n;
		n = 0;
		do
		begin
			bus(dv, 1'b0, a, 8'h00, q);
			n++;
		end
		while ((q & m) !== e && n < 200);
		chk(nm, e, q & m);
	endtask

	task automatic hcmd(input logic [7:0] c);
		wr(0, sph_pkg::H_CMD, c);
		poll(0, sph_pkg::H_STATUS, 32'h400, 32'h0, "host busy");
	endtask

	task automatic hst(input logic [31:0] e, input string nm);
		wr(0, sph_pkg::H_STATUS, 8'h00);
		poll(0, sph_pkg::H_STATUS, 32'h400, 32'h0, "host busy");
		rdc(0, sph_pkg::H_STATUS, e, nm);
	endtask

	task automatic test_done;
		if (n_errors == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ****************************
	// Tests
	// ****************************
	initial
	begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		// Reset state and unmapped places
		rdc(0, sph_pkg::H_STATUS, 32'h0, "host status");
		rdc(1, sph_pkg::MC_CTRL, 32'h0, "dev ctrl");
		rdc(0, 8'h3c, 32'h0, "host unmapped");
		rdc(1, 8'h3c, 32'h0, "dev unmapped");
		// Event report then status read
		wr(1, sph_pkg::MC_STATUS, 8'h54);
		wr(1, sph_pkg::MC_CTRL, 8'h01);
		hst(32'h155, "status read");
		// Command without acknowledge bit leaves the interrupt up
		hcmd(8'h75);
		poll(1, sph_pkg::MC_CTRL, 32'h8, 32'h8, "cmd pending");
		chk("mc irq", 32'h1, {31'h0, mc_irq});
		rdc(1, sph_pkg::MC_LATCH, 32'h75, "latch");
		rdc(1, sph_pkg::MC_CTRL, 32'h1, "ctrl after read");
		hst(32'h155, "irq held");
		// Acknowledge bit clears interrupt and status bit zero
		hcmd(8'h83);
		poll(1, sph_pkg::MC_CTRL, 32'h8, 32'h8, "cmd pending");
		rdc(1, sph_pkg::MC_LATCH, 32'h83, "ack latch");
		hst(32'h054, "irq cleared");
		// Memory to device, two bytes
		wr(0, sph_pkg::H_MEM_PTR, 8'h02);
		wr(0, sph_pkg::H_MEM_DATA, 8'ha5);
		wr(0, sph_pkg::H_MEM_PTR, 8'h03);
		wr(0, sph_pkg::H_MEM_DATA, 8'h3c);
		wr(0, sph_pkg::H_MEM_PTR, 8'h02);
		wr(0, sph_pkg::H_DMA_CNT, 8'h02);
		wr(0, sph_pkg::H_DMA_CTRL, 8'h01);
		wr(1, sph_pkg::MC_STATUS, 8'h02);
		wr(1, sph_pkg::MC_CTRL, 8'h02);
		rdc(1, sph_pkg::MC_LATCH, 32'h83, "latch before");
		poll(0, sph_pkg::H_DMA_CNT, 32'hff, 32'h1, "dma count");
		rdc(1, sph_pkg::MC_LATCH, 32'ha5, "dma byte 0");
		poll(0, sph_pkg::H_DMA_CNT, 32'hff, 32'h0, "dma count");
		rdc(1, sph_pkg::MC_LATCH, 32'h3c, "dma byte 1");
		rdc(0, sph_pkg::H_MEM_PTR, 32'h4, "dma pointer");
		// Count spent: request stays until the busy bit drops
		poll(1, sph_pkg::MC_CTRL, 32'h4, 32'h4, "request held");
		wr(1, sph_pkg::MC_STATUS, 8'h00);
		poll(1, sph_pkg::MC_CTRL, 32'h4, 32'h0, "request gated");
		// Device to memory, one byte
		wr(0, sph_pkg::H_MEM_PTR, 8'h08);
		wr(0, sph_pkg::H_DMA_CNT, 8'h01);
		wr(0, sph_pkg::H_DMA_CTRL, 8'h03);
		wr(1, sph_pkg::MC_CTRL, 8'h00);
		wr(1, sph_pkg::MC_STATUS, 8'h02);
		wr(1, sph_pkg::MC_LATCH, 8'h6e);
		poll(0, sph_pkg::H_DMA_CNT, 32'hff, 32'h0, "dma count");
		poll(1, sph_pkg::MC_CTRL, 32'h4, 32'h0, "request cleared");
		wr(0, sph_pkg::H_MEM_PTR, 8'h08);
		rdc(0, sph_pkg::H_MEM_DATA, 32'h6e, "memory byte");
		test_done;
	end

	// Watchdog, far beyond the few hundred cycles the tests need
	initial
	begin
		repeat (20000) @(posedge clk_i);
		n_errors++;
		test_done;
	end
endmodule // slave_port_host_interface_tb
